// >>> rtl/qpd_regs.svh
`ifndef QPD_REGS_SVH
`define QPD_REGS_SVH
// Operation
// - chip select low opens a frame and drives serial data out.
// - each rising serial clock edge presents the next outgoing bit.
// - outgoing frame holds latches, thermal, reset levels, overcurrent.
// - last outgoing bit is a framing marker, not status.
// - each falling serial clock edge captures one incoming bit.
// - incoming frame carries four 4-bit duty codes, one per channel.
// - chip select rising commits the received word as new settings.
// - with chip select high, output floats and input is ignored.
// - data passes through unchanged so two devices can be chained.
// - commit only when clock count is a nonzero multiple of 16.
// - code zero keeps the output off; diagnosis still runs.
// - channels are staggered so no two outputs switch together.
// - undervoltage forces all outputs off.
// - after a reset only a valid transfer re-enables outputs.
// - overcurrent trip switches that output off.
// - overcurrent state latched at pwm falling edge, per channel.
// - pwm rising edge latches the flyback comparator.
// - pwm falling edge latches the off-state comparator.
// - thermal flag is 0 on overtemperature, 1 when normal.
// - framing marker bit is always one.
// - duty codes in nibbles, channel one at bits 3..0, lsb first.
// - outgoing layout: latches 7..0, resets 9..8, thermal 10, oc 14..11.
// - overcurrent block lasts until the next pwm cycle starts.
`define QPD_FRAME_W   16
`define QPD_NCH       4
`define QPD_CODE_W    4
`define QPD_LAST_BIT  4'hf
`define QPD_SEQ_BIT   4'h1
`define QPD_STAGGER   4'h4
`define QPD_FULL_ON   4'hf
`define QPD_OSC_DIV   2
`define QPD_DIAG_RES  8
`define QPD_DIAG_TH   10
`define QPD_DIAG_OC   11
`define QPD_DIAG_MARK 15
`define QPD_MARK_VAL  1'b1
`endif

// >>> rtl/qpd_pkg.sv
`include "qpd_regs.svh"
package qpd_pkg;
    // comparator inputs, one bit per channel
    typedef struct packed {
        logic [`QPD_NCH-1:0] fly;
        logic [`QPD_NCH-1:0] off;
        logic [`QPD_NCH-1:0] oc;
    } qpd_cmp_type;
    // slow pins that cross into the system clock
    typedef struct packed {
        logic cs_n;
        logic osc;
        logic uv;
        logic ot;
        logic res_a;
        logic res_b;
    } qpd_pin_type;
    typedef struct packed {
        logic [`QPD_FRAME_W-1:0] sh;
        logic [`QPD_CODE_W-1:0]  cnt;
        logic                    mult;
        logic                    seq;
    } qpd_rx_type;
    typedef struct packed {
        logic [`QPD_CODE_W-1:0] cnt;
        logic                   mult;
        logic                   sdo;
    } qpd_tx_type;
endpackage : qpd_pkg

// >>> rtl/qpd_top.sv
`timescale 1ns/10ps
`include "qpd_regs.svh"

// ============================================================
// link receive side, falling edge of the serial clock
// ============================================================
module qpd_link_rx
    import qpd_pkg::*;
(
    // link
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       sdi_i,
    input  wire logic       rst_i,
    // count from the transmit side
    input  wire qpd_tx_type tx_i,
    // received state
    output qpd_rx_type      rx_o
);
    qpd_rx_type rx_r;
    qpd_rx_type rx_nxt;

    // not cleared by chip select: the word must survive until commit
    always_comb begin
        rx_nxt = rx_r;
        if (!cs_n_i) begin
            rx_nxt.sh   = {sdi_i, rx_r.sh[`QPD_FRAME_W-1:1]};
            rx_nxt.cnt  = tx_i.cnt;
            rx_nxt.mult = tx_i.mult;
            // first falling edge of a frame marks the frame as fresh
            if (tx_i.cnt == `QPD_SEQ_BIT && !tx_i.mult) begin
                rx_nxt.seq = !rx_r.seq;
            end
        end
    end

    // reset only while the serial clock is idle
    always_ff @(negedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_r <= '0;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    assign rx_o = rx_r;
endmodule : qpd_link_rx

// ============================================================
// link transmit side, rising edge of the serial clock
// ============================================================
module qpd_link_tx
    import qpd_pkg::*;
(
    // link
    input  wire logic                    sclk_i,
    input  wire logic                    cs_n_i,
    // frame to send and bit to pass on
    input  wire logic [`QPD_FRAME_W-1:0] diag_i,
    input  wire logic                    pass_i,
    // transmit state
    output qpd_tx_type                   tx_o,
    output logic                         sdo_o
);
    qpd_tx_type tx_r;
    qpd_tx_type tx_nxt;

    // first 15 rises send bits 1..15 of the frame, the 16th and later rises pass input through
    always_comb begin
        tx_nxt     = tx_r;
        tx_nxt.cnt = 4'(tx_r.cnt + 4'h1);
        if (!tx_r.mult && tx_r.cnt != `QPD_LAST_BIT) begin
            tx_nxt.sdo = diag_i[4'(tx_r.cnt + 4'h1)];
        end else begin
            tx_nxt.sdo = pass_i;
        end
        if (tx_r.cnt == `QPD_LAST_BIT) begin
            tx_nxt.mult = 1'b1;
        end
    end

    // chip select high clears the frame; constants only
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            tx_r <= '0;
        end else begin
            tx_r <= tx_nxt;
        end
    end

    // bit 0 stands before the first rise
    assign sdo_o = (tx_r.cnt == '0 && !tx_r.mult) ? diag_i[0]
                                                  : tx_r.sdo;
    assign tx_o  = tx_r;
endmodule : qpd_link_tx

// ============================================================
// top: commit, pwm, diagnosis, protection
// ============================================================
module qpd_top
    import qpd_pkg::*;
#(
    parameter int OSC_DIV = `QPD_OSC_DIV
)(
    // system
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // serial link
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_n_o,
    // timebase and supervision pins
    input  wire logic              osc_i,
    input  wire logic              undervoltage_i,
    input  wire logic              overtemp_i,
    input  wire logic              ext_reset_input_a_n_i,
    input  wire logic              ext_reset_input_b_n_i,
    // output comparators
    input  wire qpd_cmp_type       cmp_i,
    // outputs
    output logic [`QPD_NCH-1:0]    drv_o,
    output logic [`QPD_NCH-1:0]    pwm_signal_o,
    output logic                   active_o
);
    localparam int DW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(OSC_DIV - 1);

    typedef struct packed {
        qpd_pin_type             p1;
        qpd_pin_type             p2;
        logic                    cs_d;
        qpd_cmp_type             c1;
        qpd_cmp_type             c2;
        logic                    osc_d;
        logic [DW-1:0]           pre;
        logic [`QPD_CODE_W-1:0]  step;
        logic [`QPD_NCH-1:0]     tdly;
        logic [`QPD_FRAME_W-1:0] duty;
        logic                    enable;
        logic                    last_seq;
        logic [`QPD_NCH-1:0]     pwm;
        logic [`QPD_NCH-1:0]     drv;
        logic [`QPD_NCH-1:0]     blk;
        logic [`QPD_NCH-1:0]     on_l;
        logic [`QPD_NCH-1:0]     off_l;
        logic [`QPD_NCH-1:0]     ocf;
        logic [`QPD_FRAME_W-1:0] diag;
    } qpd_sys_type;

    qpd_sys_type             sys_r;
    qpd_sys_type             sys_nxt;
    qpd_pin_type             pins;
    qpd_rx_type              rx;
    qpd_tx_type              tx;
    qpd_pin_type             ps;
    logic                    tick;
    logic                    cs_rise;
    logic                    good;
    logic [`QPD_CODE_W-1:0]  code;
    logic [`QPD_CODE_W-1:0]  phase;
    logic [`QPD_CODE_W-1:0]  on_cnt;
    logic                    newp;
    logic [`QPD_FRAME_W-1:0] dw;
    logic [`QPD_NCH-1:0]     zero_m;

    // pins gathered for the synchroniser
    assign pins.cs_n  = cs_n_i;
    assign pins.osc   = osc_i;
    assign pins.uv    = undervoltage_i;
    assign pins.ot    = overtemp_i;
    assign pins.res_a = ext_reset_input_a_n_i;
    assign pins.res_b = ext_reset_input_b_n_i;
    assign ps         = sys_r.p2;

    // ========================================================
    // link domain
    // ========================================================
    qpd_link_rx i_qpd_link_rx (
        .sclk_i (sclk_i),
        .cs_n_i (cs_n_i),
        .sdi_i  (sdi_i),
        .rst_i  (rst_i),
        .tx_i   (tx),
        .rx_o   (rx)
    );

    // diag is frozen while selected, so the link reads a steady word
    qpd_link_tx i_qpd_link_tx (
        .sclk_i (sclk_i),
        .cs_n_i (cs_n_i),
        .diag_i (sys_r.diag),
        .pass_i (rx.sh[1]),
        .tx_o   (tx),
        .sdo_o  (sdo_o)
    );

    // drive enable follows chip select directly
    assign sdo_oe_n_o = cs_n_i;

    // ========================================================
    // system domain next state
    // ========================================================
    always_comb begin
        sys_nxt = sys_r;
        code    = '0;
        phase   = '0;
        on_cnt  = '0;
        newp    = 1'b0;
        dw      = '0;
        // two-stage synchronisers
        sys_nxt.p1    = pins;
        sys_nxt.p2    = sys_r.p1;
        sys_nxt.c1    = cmp_i;
        sys_nxt.c2    = sys_r.c1;
        sys_nxt.cs_d  = ps.cs_n;
        sys_nxt.osc_d = ps.osc;

        // timebase: OSC_DIV oscillator edges per pwm step
        tick = 1'b0;
        if (ps.osc && !sys_r.osc_d) begin
            if (sys_r.pre == DIV_LAST) begin
                sys_nxt.pre  = '0;
                sys_nxt.step = 4'(sys_r.step + 4'h1);
                tick         = 1'b1;
            end else begin
                sys_nxt.pre = DW'(sys_r.pre + 1'b1);
            end
        end
        // each channel acts on its own cycle after the step
        sys_nxt.tdly = {sys_r.tdly[`QPD_NCH-2:0], tick};

        // commit; the rx word is quiet once chip select is high
        cs_rise = ps.cs_n && !sys_r.cs_d;
        good    = cs_rise && rx.cnt == '0 && rx.mult
                  && rx.seq != sys_r.last_seq;
        if (cs_rise) begin
            sys_nxt.last_seq = rx.seq;
        end
        if (good) begin
            sys_nxt.duty   = rx.sh;
            sys_nxt.enable = 1'b1;
        end
        // a driver reset wins over a commit in the same cycle
        if (!ps.res_a || !ps.res_b) begin
            sys_nxt.enable = 1'b0;
            sys_nxt.duty   = '0;
        end

        // per channel pwm, edge latches and protection
        for (int c = 0; c < `QPD_NCH; c++) begin
            // new settings and driver resets reach drv in the same cycle
            code   = sys_nxt.duty[c*`QPD_CODE_W +: `QPD_CODE_W];
            phase  = 4'(sys_nxt.step - 4'(c) * `QPD_STAGGER);
            // code zero still runs the signal so diagnosis keeps going
            on_cnt = (code == '0) ? `QPD_FULL_ON : code;
            newp   = phase < on_cnt;
            if (sys_r.tdly[c]) begin
                sys_nxt.pwm[c] = newp;
                if (newp && !sys_r.pwm[c]) begin
                    sys_nxt.on_l[c] = sys_r.c2.fly[c];
                    sys_nxt.blk[c]  = 1'b0;
                end
                if (!newp && sys_r.pwm[c]) begin
                    sys_nxt.off_l[c] = sys_r.c2.off[c];
                    sys_nxt.ocf[c]   = !sys_r.c2.oc[c];
                end
            end
            // a trip in the clearing cycle still blocks
            if (sys_r.c2.oc[c]) begin
                sys_nxt.blk[c] = 1'b1;
            end
            sys_nxt.drv[c] = sys_nxt.pwm[c] && code != '0
                             && sys_nxt.enable && !ps.uv
                             && !sys_nxt.blk[c];
            dw[2*c]     = sys_nxt.on_l[c];
            dw[2*c + 1] = sys_nxt.off_l[c];
            dw[`QPD_DIAG_OC + c] = sys_nxt.ocf[c];
        end

        // diagnostic frame, refreshed only between frames
        dw[`QPD_DIAG_RES]     = ps.res_a;
        dw[`QPD_DIAG_RES + 1] = ps.res_b;
        dw[`QPD_DIAG_TH]      = !ps.ot;
        dw[`QPD_DIAG_MARK]    = `QPD_MARK_VAL;
        if (ps.cs_n) begin
            sys_nxt.diag = dw;
        end
    end

    // ce low freezes every system flip-flop
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sys_r <= '0;
            // pins start at idle levels so no false edge follows reset
            sys_r.p1.cs_n  <= 1'b1;
            sys_r.p2.cs_n  <= 1'b1;
            sys_r.cs_d     <= 1'b1;
            sys_r.p1.res_a <= 1'b1;
            sys_r.p1.res_b <= 1'b1;
            sys_r.p2.res_a <= 1'b1;
            sys_r.p2.res_b <= 1'b1;
        end else if (ce_i) begin
            sys_r <= sys_nxt;
        end
    end

    // outputs straight from flip-flops
    assign drv_o        = sys_r.drv;
    assign pwm_signal_o = sys_r.pwm;
    assign active_o     = sys_r.enable;

    // channels whose code is zero, for checking only
    always_comb begin
        zero_m = '0;
        for (int c = 0; c < `QPD_NCH; c++) begin
            zero_m[c] = sys_r.duty[c*`QPD_CODE_W +: `QPD_CODE_W] == '0;
        end
    end

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // undervoltage leaves every output off one cycle later
    chk_uv_all_off: assert property (
        (ce_i && ps.uv) |=> (sys_r.drv == '0))
        else $error("output on during undervoltage");

    // a short or empty frame leaves the settings alone
    chk_bad_frame_kept: assert property (
        (ce_i && cs_rise && !good) |=> $stable(sys_r.duty))
        else $error("invalid frame changed duty");

    // a valid frame lands as the received word
    chk_good_frame_set: assert property (
        (ce_i && good && ps.res_a && ps.res_b)
        |=> (sys_r.duty == $past(rx.sh) && sys_r.enable))
        else $error("valid frame not committed");

    // a zero code never drives its output
    chk_zero_code_off: assert property (
        (zero_m & sys_r.drv) == '0)
        else $error("zero code channel driven");

    // reset input low kills the outputs and the enable
    chk_reset_disables: assert property (
        (ce_i && !(ps.res_a && ps.res_b))
        |=> (!sys_r.enable && sys_r.drv == '0))
        else $error("outputs alive after driver reset");

    // at most one pwm signal changes in any cycle
    chk_pwm_staggered: assert property (
        $onehot0(sys_r.pwm ^ $past(sys_r.pwm)))
        else $error("two channels switched together");

    // a tripped channel is off in the next cycle
    chk_oc_trip_off: assert property (
        (ce_i && sys_r.c2.oc != '0)
        |=> ((sys_r.drv & $past(sys_r.c2.oc)) == '0))
        else $error("output on after overcurrent");

    // marker bit stays one and reset level a sits at bit 8
    chk_diag_layout: assert property (
        (ce_i && ps.cs_n) |=> (sys_r.diag[`QPD_DIAG_MARK]
        && sys_r.diag[`QPD_DIAG_RES] == $past(ps.res_a)))
        else $error("diagnostic frame layout wrong");

    // main scenarios
    cov_valid_commit: cover property (ce_i && good);
    cov_discarded: cover property (ce_i && cs_rise && !good);
    cov_oc_trip: cover property (ce_i && sys_r.blk != '0
                                 && sys_r.enable);
endmodule : qpd_top

// >>> sim/qpd_master.sv
`timescale 1ns/10ps

// ============================================================
// serial master model: link clock runs only inside frames
// ============================================================
module qpd_master (
    // link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    // idle: clock low, not selected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // lsb first both ways; sdi moves mid-low so the fall sees it settled
    task automatic xfer(input int n, input logic [31:0] dout,
                        output logic [31:0] din);
        din = '0;
        cs_n_o = 1'b0;
        #48;
        for (int i = 0; i < n; i++) begin
            sdi_o = dout[i%32];
            #12;
            din[i%32] = sdo_i;
            sclk_o = 1'b1;
            #24;
            sclk_o = 1'b0;
            #12;
        end
        #24;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line must not look held
    endtask : xfer
endmodule : qpd_master

// >>> sim/quad_pwm_driver_serial_control_tb.sv
`timescale 1ns/10ps

// ============================================================
// bench top
// ============================================================
module quad_pwm_driver_serial_control_tb;
    import qpd_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        osc       = 1'b0;
    logic        uv        = 1'b0;
    logic        ot        = 1'b0;
    logic        res_a_n   = 1'b1;
    logic        res_b_n   = 1'b1;
    logic        ce        = 1'b1;
    qpd_cmp_type cmp       = '0;
    logic        sclk, cs_n, sdi, sdo, sdo_oe_n, active;
    logic [3:0]  drv, pwm;
    logic [31:0] rd;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          on_d[4];
    int          on_p[4];
    int          coinc;

    // one pwm step per osc rise: a period is 160 system cycles
    always #5 clk_sys_i = ~clk_sys_i;
    always #50 osc = ~osc;

    qpd_top #(.OSC_DIV(1)) i_qpd_top (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n), .osc_i(osc), .undervoltage_i(uv),
        .overtemp_i(ot), .ext_reset_input_a_n_i(res_a_n),
        .ext_reset_input_b_n_i(res_b_n), .cmp_i(cmp), .drv_o(drv),
        .pwm_signal_o(pwm), .active_o(active));

    qpd_master i_qpd_master (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .sdo_i(sdo));

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // one frame; output enable watched mid-frame and after the commit
    task automatic frame(input int n, input logic [31:0] dout);
        fork
            i_qpd_master.xfer(n, dout, rd);
            begin
                #40;
                check("sdo enable", sdo_oe_n, 1'b0);
            end
        join
        repeat (10) @(negedge clk_sys_i);
        check("sdo release", sdo_oe_n, 1'b1);
    endtask : frame

    // counts high cycles over exactly one pwm period
    task automatic measure();
        logic [3:0] prev;
        on_d = '{default: 0};
        on_p = '{default: 0};
        coinc = 0;
        repeat (170) @(negedge clk_sys_i);
        prev = pwm;
        repeat (160) begin
            @(negedge clk_sys_i);
            // an unknown output would count as off, so it fails here
            if ($countones(pwm ^ prev) > 1 || $isunknown({drv, pwm}))
                coinc++;
            prev = pwm;
            for (int c = 0; c < 4; c++) begin
                on_d[c] += int'(drv[c]);
                on_p[c] += int'(pwm[c]);
            end
        end
    endtask : measure

    task automatic expect_duty(input logic [15:0] codes, input logic en);
        logic [3:0] k;
        measure();
        for (int c = 0; c < 4; c++) begin
            k = codes[4*c+:4];
            check("pwm on", on_p[c], (k == 0) ? 150 : k * 10);
            check("drv on", on_d[c], en ? k * 10 : 0);
        end
        check("same-cycle edges", coinc, 0);
    endtask : expect_duty

    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_reset();
        check("drv after reset", drv, 4'h0);
        check("active after reset", active, 1'b0);
        check("sdo idle", sdo_oe_n, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_frame();
        frame(16, 32'h180f);
        check("framing bit", rd[15], 1'b1);
        check("levels", rd[10:8], 3'h7);
        check("active", active, 1'b1);
        expect_duty(16'h180f, 1'b1);
        $display("test frame done");
    endtask : t_frame

    // 15 and 17 clocks refused; 32-clock frame keeps the last 16 bits
    task automatic t_count();
        frame(15, 32'h0);
        frame(17, 32'h1ffff);
        expect_duty(16'h180f, 1'b1);
        frame(32, 32'h4321abcd);
        check("pass through", rd[31:16], 16'habcd);
        expect_duty(16'h4321, 1'b1);
        $display("test count done");
    endtask : t_count

    task automatic t_uv();
        @(negedge clk_sys_i);
        uv = 1'b1;
        expect_duty(16'h4321, 1'b0);
        uv = 1'b0;
        expect_duty(16'h4321, 1'b1);
        $display("test undervoltage done");
    endtask : t_uv

    // only a transfer brings outputs back after a driver reset
    task automatic t_rst_in();
        @(negedge clk_sys_i);
        res_a_n = 1'b0;
        // let the level pass the synchroniser before the diag word freezes
        repeat (5) @(negedge clk_sys_i);
        frame(16, 32'h4321);
        check("reset levels", rd[9:8], 2'h2);
        check("active held", active, 1'b0);
        @(negedge clk_sys_i);
        res_a_n = 1'b1;
        // an empty frame must not revive the word kept from before
        frame(0, 32'h0);
        check("empty frame", active, 1'b0);
        // the driver reset cleared every code as well
        expect_duty(16'h0000, 1'b0);
        frame(16, 32'h4321);
        expect_duty(16'h4321, 1'b1);
        $display("test driver reset done");
    endtask : t_rst_in

    // codes chosen long enough for every latch to see its edge
    task automatic t_diag();
        @(negedge clk_sys_i);
        ot = 1'b1;
        cmp = {4'h5, 4'ha, 4'h1};
        measure();
        check("oc drv ch1", on_d[0], 0);
        check("oc drv ch3", on_d[2], 30);
        frame(16, 32'h4321);
        check("diag word", rd[15:0], 16'hf399);
        @(negedge clk_sys_i);
        ot = 1'b0;
        cmp = '0;
        expect_duty(16'h4321, 1'b1);
        frame(16, 32'h4321);
        check("thermal back", rd[10], 1'b1);
        $display("test diagnosis done");
    endtask : t_diag

    // clock enable low holds the timebase and outputs where they stand
    task automatic t_freeze();
        logic [3:0] d0;
        logic [3:0] p0;
        @(negedge clk_sys_i);
        ce = 1'b0;
        @(negedge clk_sys_i);
        d0 = drv;
        p0 = pwm;
        repeat (40) @(negedge clk_sys_i);
        check("frozen drv", drv, d0);
        check("frozen pwm", pwm, p0);
        ce = 1'b1;
        $display("test freeze done");
    endtask : t_freeze

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        t_reset();
        t_frame();
        t_count();
        t_uv();
        t_rst_in();
        t_freeze();
        t_diag();
        finish_test();
    end
endmodule : quad_pwm_driver_serial_control_tb
